/* priv_reg_model.sv */
// Architectural registers, privilege checks and line fill sequencing
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Sixteen 32-bit general registers, status word, three stack pointers, eight control registers
// - Stack pointer chosen by mode and master bit
// - User mode reaches only the low status byte
// - Block access controls only in supervisor mode
// - Source and destination 3-bit space codes
// - Space codes made automatically per access
// - Vector address from table base and number
// - Independent instruction and data cache enables
// - Two fetch and two operand block controls
// - Write policy per 16M to 4G block
// - Write protect per operand block, cache mode per block
// - Line fill by four long word burst
// - Byte, word, long and line transfer sizes
// - Pending writes wait while a fill runs
module priv_reg_model
    import ctl_model_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [ctl_model_pkg::IDX_W-1:0] reg_addr_in,
    input wire logic [ctl_model_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ctl_model_pkg::DATA_W-1:0] reg_rdata_out,
    output logic priv_viol_out,
    output logic super_mode_out,
    input wire logic access_prog_in,
    input wire logic alt_src_in,
    input wire logic alt_dst_in,
    output logic [2:0] fc_out,
    input wire logic [7:0] vector_num_in,
    output logic [31:0] vector_addr_out,
    output logic icache_en_out,
    output logic dcache_en_out,
    input wire logic [31:0] fetch_addr_in,
    output logic fetch_hit_out,
    output ctl_model_pkg::cmode_t fetch_cmode_out,
    input wire logic [31:0] data_addr_in,
    input wire logic data_write_in,
    output logic data_hit_out,
    output ctl_model_pkg::cmode_t data_cmode_out,
    output logic data_wp_fault_out,
    input wire logic miss_in,
    input wire logic [31:0] miss_addr_in,
    input wire logic beat_ack_in,
    output logic fill_req_out,
    output logic [31:0] fill_addr_out,
    output logic fill_last_out,
    input wire logic wr_pend_in,
    input wire ctl_model_pkg::size_t wr_size_in,
    output logic wr_go_out,
    output ctl_model_pkg::size_t xfer_size_out
);
    import ctl_model_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // The status word and every index from USP through OPND1 are supervisor-only
    function automatic logic is_priv(input logic [5:0] idx);
        return (idx == IDX_STATUS) || (idx > IDX_FLAGS && idx <= IDX_OPND1);
    endfunction : is_priv

    function automatic logic in_mem(input logic [5:0] idx);
        return (idx <= IDX_A7) || (idx >= IDX_USP && idx <= IDX_MSP);
    endfunction : in_mem

    // The active stack pointer follows the mode bits of the status word
    function automatic logic [4:0] mem_slot(input logic [5:0] idx,
                                            input logic s,
                                            input logic m);
        logic [4:0] slot;
        slot = idx[4:0];
        if (idx == IDX_A7) begin
            slot = !s ? MEM_USP : (m ? MEM_MSP : MEM_ISP);
        end else if (idx == IDX_USP) begin
            slot = MEM_USP;
        end else if (idx == IDX_ISP) begin
            slot = MEM_ISP;
        end else if (idx == IDX_MSP) begin
            slot = MEM_MSP;
        end
        return slot;
    endfunction : mem_slot

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [15:0] status_r;
    logic [31:0] vbr_r;
    logic [2:0] sfc_r;
    logic [2:0] dfc_r;
    logic [31:0] cache_ctl_r;
    logic [31:0] fetch_ctl_r [2];
    logic [31:0] opnd_ctl_r [2];
    logic sup;
    logic viol;
    logic wr_ok;
    logic [4:0] mem_addr;
    logic [31:0] mem_q;
    logic sel_mem_r;
    logic [31:0] ctl_q_r;

    assign sup = status_r[SW_S_BIT];
    assign viol = (reg_wr_in || reg_rd_in) && !sup
                  && is_priv(reg_addr_in);
    assign wr_ok = reg_wr_in && !viol;
    assign mem_addr = mem_slot(reg_addr_in, sup, status_r[SW_M_BIT]);

    gpr_store #(
        .W(DATA_W),
        .DEPTH(MEM_DEPTH),
        .AW(MEM_AW)
    ) u_store (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .we_in(wr_ok && in_mem(reg_addr_in)),
        .waddr_in(mem_addr),
        .wdata_in(reg_wdata_in),
        .raddr_in(mem_addr),
        .rdata_out(mem_q)
    );

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= SW_RESET;
        end else if (wr_ok && reg_addr_in == IDX_STATUS) begin
            status_r <= reg_wdata_in[15:0];
        end else if (reg_wr_in && reg_addr_in == IDX_FLAGS) begin
            status_r[7:0] <= reg_wdata_in[7:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            vbr_r <= 32'h0;
            sfc_r <= 3'h0;
            dfc_r <= 3'h0;
            cache_ctl_r <= 32'h0;
        end else if (wr_ok) begin
            case (reg_addr_in)
                IDX_VBR: vbr_r <= reg_wdata_in;
                IDX_SFC: sfc_r <= reg_wdata_in[2:0];
                IDX_DFC: dfc_r <= reg_wdata_in[2:0];
                IDX_CACHE: cache_ctl_r <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // One fetch and one operand control per generate step
    for (genvar i = 0; i < 2; i++) begin : g_blk
        always_ff @(posedge mclk_in or negedge rst_n) begin
            if (!rst_n) begin
                fetch_ctl_r[i] <= 32'h0;
                opnd_ctl_r[i] <= 32'h0;
            end else if (wr_ok) begin
                if (reg_addr_in == IDX_FETCH0 + 6'(i)) begin
                    fetch_ctl_r[i] <= reg_wdata_in;
                end
                if (reg_addr_in == IDX_OPND0 + 6'(i)) begin
                    opnd_ctl_r[i] <= reg_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            sel_mem_r <= 1'b0;
            ctl_q_r <= 32'h0;
            priv_viol_out <= 1'b0;
        end else begin
            priv_viol_out <= viol;
            sel_mem_r <= reg_rd_in && !viol && in_mem(reg_addr_in);
            ctl_q_r <= 32'h0;
            if (reg_rd_in && !viol) begin
                case (reg_addr_in)
                    IDX_STATUS: ctl_q_r <= {16'h0, status_r};
                    IDX_FLAGS: ctl_q_r <= {24'h0, status_r[7:0]};
                    IDX_VBR: ctl_q_r <= vbr_r;
                    IDX_SFC: ctl_q_r <= {29'h0, sfc_r};
                    IDX_DFC: ctl_q_r <= {29'h0, dfc_r};
                    IDX_CACHE: ctl_q_r <= cache_ctl_r;
                    IDX_FETCH0: ctl_q_r <= fetch_ctl_r[0];
                    IDX_FETCH1: ctl_q_r <= fetch_ctl_r[1];
                    IDX_OPND0: ctl_q_r <= opnd_ctl_r[0];
                    IDX_OPND1: ctl_q_r <= opnd_ctl_r[1];
                    default: ctl_q_r <= 32'h0;
                endcase
            end
        end
    end

    assign reg_rdata_out = sel_mem_r ? mem_q : ctl_q_r;

    // ----------------------------------------------------------------
    // Space codes, vectors and cache enables
    // ----------------------------------------------------------------
    logic [2:0] fc_nxt;

    always_comb begin
        if (alt_src_in) begin
            fc_nxt = sfc_r;
        end else if (alt_dst_in) begin
            fc_nxt = dfc_r;
        end else if (sup) begin
            fc_nxt = access_prog_in ? FC_SPROG : FC_SDATA;
        end else begin
            fc_nxt = access_prog_in ? FC_UPROG : FC_UDATA;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            fc_out <= FC_SPROG;
            super_mode_out <= 1'b1;
            vector_addr_out <= 32'h0;
        end else begin
            fc_out <= fc_nxt;
            super_mode_out <= sup;
            // Each table entry is one long word
            vector_addr_out <= vbr_r
                               + {22'h0, vector_num_in, 2'b00};
        end
    end

    assign icache_en_out = cache_ctl_r[CE_IC_BIT];
    assign dcache_en_out = cache_ctl_r[CE_DC_BIT];

    // ----------------------------------------------------------------
    // Block access matching
    // ----------------------------------------------------------------
    logic f_hit;
    logic d_hit;
    logic d_wp;
    cmode_t f_cm;
    cmode_t d_cm;

    block_match u_fetch (
        .addr_in(fetch_addr_in),
        .ctl0_in(fetch_ctl_r[0]),
        .ctl1_in(fetch_ctl_r[1]),
        .hit_out(f_hit),
        .wp_out(),
        .cmode_out(f_cm)
    );

    block_match u_opnd (
        .addr_in(data_addr_in),
        .ctl0_in(opnd_ctl_r[0]),
        .ctl1_in(opnd_ctl_r[1]),
        .hit_out(d_hit),
        .wp_out(d_wp),
        .cmode_out(d_cm)
    );

    // A disabled cache forces every access uncached regardless of blocks
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            fetch_hit_out <= 1'b0;
            fetch_cmode_out <= CM_NOCACHE;
            data_hit_out <= 1'b0;
            data_cmode_out <= CM_NOCACHE;
            data_wp_fault_out <= 1'b0;
        end else begin
            fetch_hit_out <= f_hit;
            fetch_cmode_out <= icache_en_out ? f_cm : CM_NOCACHE;
            data_hit_out <= d_hit;
            data_cmode_out <= dcache_en_out ? d_cm : CM_NOCACHE;
            data_wp_fault_out <= d_wp && data_write_in;
        end
    end

    // ----------------------------------------------------------------
    // Line fill sequencer
    // ----------------------------------------------------------------
    typedef enum logic {FILL_IDLE, FILL_RUN} fill_state_t;
    fill_state_t fill_state_r;
    logic [27:0] line_r;
    logic [1:0] beat_r;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            fill_state_r <= FILL_IDLE;
            line_r <= 28'h0;
            beat_r <= 2'h0;
        end else begin
            case (fill_state_r)
                FILL_IDLE: begin
                    if (miss_in) begin
                        fill_state_r <= FILL_RUN;
                        line_r <= miss_addr_in[31:4];
                        beat_r <= 2'h0;
                    end
                end
                FILL_RUN: begin
                    if (beat_ack_in) begin
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == LAST_BEAT) begin
                            fill_state_r <= FILL_IDLE;
                        end
                    end
                end
                default: fill_state_r <= FILL_IDLE;
            endcase
        end
    end

    assign fill_req_out = (fill_state_r == FILL_RUN);
    assign fill_addr_out = {line_r, beat_r, 2'b00};
    assign fill_last_out = fill_req_out && (beat_r == LAST_BEAT);
    // Reads for missing lines go ahead of buffered writes
    assign wr_go_out = wr_pend_in && !fill_req_out && !miss_in;
    assign xfer_size_out = fill_req_out ? SZ_LINE : wr_size_in;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    a_a7_user_map: assert property (
        (reg_rd_in && reg_addr_in == IDX_A7 && !sup)
        |-> mem_addr == MEM_USP)
        else $error("user stack pointer not selected");
    a_a7_super_map: assert property (
        (reg_rd_in && reg_addr_in == IDX_A7 && sup)
        |-> mem_addr == (status_r[SW_M_BIT] ? MEM_MSP : MEM_ISP))
        else $error("supervisor stack pointer wrong");
    a_flags_user_write: assert property (
        (reg_wr_in && reg_addr_in == IDX_FLAGS && !sup)
        |=> status_r[15:8] == $past(status_r[15:8], 1)
            && status_r[7:0] == $past(reg_wdata_in[7:0], 1))
        else $error("flags write touched upper byte");
    a_priv_no_change: assert property (
        (reg_wr_in && reg_addr_in == IDX_VBR && !sup)
        |=> priv_viol_out && $stable(vbr_r))
        else $error("privileged write not blocked");
    a_block_guard: assert property (
        (reg_wr_in && reg_addr_in == IDX_OPND1 && !sup)
        |=> priv_viol_out && $stable(opnd_ctl_r[1]))
        else $error("block control written in user mode");
    a_fc_auto: assert property (
        (!alt_src_in && !alt_dst_in && !sup && access_prog_in)
        |=> fc_out == FC_UPROG)
        else $error("user program code wrong");
    a_vector_base: assert property (
        ##1 vector_addr_out == $past(vbr_r, 1)
            + {22'h0, $past(vector_num_in, 1), 2'b00})
        else $error("vector address wrong");
    a_fill_start: assert property (
        (!fill_req_out && miss_in)
        |=> fill_req_out && fill_addr_out[3:0] == 4'h0)
        else $error("fill not line aligned");
    a_fill_four: assert property (
        (fill_req_out && beat_ack_in && beat_r == LAST_BEAT)
        |=> !fill_req_out)
        else $error("fill did not end after four beats");
    a_write_defer: assert property (
        fill_req_out |-> !wr_go_out && xfer_size_out == SZ_LINE)
        else $error("write went during fill");

    c_full_fill: cover property (fill_last_out && beat_ack_in);
    c_user_viol: cover property (priv_viol_out);
    c_msp_read: cover property (
        reg_rd_in && reg_addr_in == IDX_A7 && sup && status_r[SW_M_BIT]);
endmodule : priv_reg_model
`default_nettype wire

/* ctl_model_pkg.sv */
// Constants and types shared by the privileged register model
package ctl_model_pkg;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int MEM_AW = 5;
    localparam int MEM_DEPTH = 32;

    // Register port indices
    localparam logic [5:0] IDX_A7 = 6'h0f;
    localparam logic [5:0] IDX_STATUS = 6'h10;
    localparam logic [5:0] IDX_FLAGS = 6'h11;
    localparam logic [5:0] IDX_USP = 6'h12;
    localparam logic [5:0] IDX_ISP = 6'h13;
    localparam logic [5:0] IDX_MSP = 6'h14;
    localparam logic [5:0] IDX_VBR = 6'h15;
    localparam logic [5:0] IDX_SFC = 6'h16;
    localparam logic [5:0] IDX_DFC = 6'h17;
    localparam logic [5:0] IDX_CACHE = 6'h18;
    localparam logic [5:0] IDX_FETCH0 = 6'h19;
    localparam logic [5:0] IDX_FETCH1 = 6'h1a;
    localparam logic [5:0] IDX_OPND0 = 6'h1b;
    localparam logic [5:0] IDX_OPND1 = 6'h1c;

    // Storage slots for the three stack pointers
    localparam logic [4:0] MEM_USP = 5'h0f;
    localparam logic [4:0] MEM_ISP = 5'h10;
    localparam logic [4:0] MEM_MSP = 5'h11;

    // Status word fields and reset value
    localparam int SW_S_BIT = 13;
    localparam int SW_M_BIT = 12;
    localparam logic [15:0] SW_RESET = 16'h2700;

    // Cache enable control fields
    localparam int CE_IC_BIT = 0;
    localparam int CE_DC_BIT = 1;

    // Block access control fields
    localparam int BA_BASE_HI = 31;
    localparam int BA_BASE_LO = 24;
    localparam int BA_MASK_HI = 23;
    localparam int BA_MASK_LO = 16;
    localparam int BA_EN_BIT = 15;
    localparam int BA_CM_HI = 6;
    localparam int BA_CM_LO = 5;
    localparam int BA_WP_BIT = 2;

    // Automatic address space codes
    localparam logic [2:0] FC_UDATA = 3'h1;
    localparam logic [2:0] FC_UPROG = 3'h2;
    localparam logic [2:0] FC_SDATA = 3'h5;
    localparam logic [2:0] FC_SPROG = 3'h6;

    localparam logic [1:0] LAST_BEAT = 2'h3;

    typedef enum logic [1:0] {
        CM_WTHRU, CM_COPYBACK, CM_SERIAL, CM_NOCACHE
    } cmode_t;
    typedef enum logic [1:0] {SZ_LONG, SZ_BYTE, SZ_WORD, SZ_LINE} size_t;
endpackage : ctl_model_pkg

/* gpr_store.sv */
// Register storage with a registered read port
`timescale 1ns/100ps
`default_nettype none
module gpr_store #(
    parameter int W = 32,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [W-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [W-1:0] rdata_out
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge mclk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule : gpr_store
`default_nettype wire

/* block_match.sv */
// Matches an address against a pair of block access controls
`timescale 1ns/100ps
`default_nettype none
module block_match
    import ctl_model_pkg::*;
(
    input wire logic [31:0] addr_in,
    input wire logic [31:0] ctl0_in,
    input wire logic [31:0] ctl1_in,
    output logic hit_out,
    output logic wp_out,
    output ctl_model_pkg::cmode_t cmode_out
);
    // Mask bits widen a block from 16 Mbytes up to the full 4 Gbytes
    function automatic logic hit(input logic [31:0] c, input logic [7:0] a);
        logic [7:0] diff;
        diff = (a ^ c[BA_BASE_HI:BA_BASE_LO]) & ~c[BA_MASK_HI:BA_MASK_LO];
        return c[BA_EN_BIT] && (diff == 8'h00);
    endfunction : hit

    logic h0;
    logic h1;
    logic [31:0] sel;

    assign h0 = hit(ctl0_in, addr_in[31:24]);
    assign h1 = hit(ctl1_in, addr_in[31:24]);
    // Block 0 wins where both match
    assign sel = h0 ? ctl0_in : ctl1_in;
    assign hit_out = h0 || h1;
    assign wp_out = hit_out && sel[BA_WP_BIT];
    assign cmode_out = hit_out ? cmode_t'(sel[BA_CM_HI:BA_CM_LO])
                               : CM_WTHRU;
endmodule : block_match
`default_nettype wire

/* priv_reg_model_bench.sv */
// Self-checking bench for the privileged register model
`timescale 1ns/100ps
`default_nettype none
module priv_reg_model_bench;
    import ctl_model_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [5:0] ra = 6'h00;
    logic [31:0] wd = 32'h0, fa = 32'h0, da = 32'h0, ma = 32'h0;
    logic ap = 1'b0, as = 1'b0, ad = 1'b0, dw = 1'b0;
    logic miss = 1'b0, ack = 1'b0, pend = 1'b0;
    logic [7:0] vn = 8'h00;
    size_t wsz = SZ_WORD;
    logic [31:0] rdat, vaddr, faddr;
    logic viol, sup, ic, dc, fhit, dhit, wpf, freq, flast, wgo;
    logic [2:0] fc;
    cmode_t fcm, dcm;
    size_t xsz;
    int mismatches = 0;
    int n_checks = 0;

    priv_reg_model dut (.mclk_in(clk), .resetn_in(rst_n),
        .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .priv_viol_out(viol),
        .super_mode_out(sup), .access_prog_in(ap), .alt_src_in(as),
        .alt_dst_in(ad), .fc_out(fc), .vector_num_in(vn),
        .vector_addr_out(vaddr), .icache_en_out(ic), .dcache_en_out(dc),
        .fetch_addr_in(fa), .fetch_hit_out(fhit), .fetch_cmode_out(fcm),
        .data_addr_in(da), .data_write_in(dw), .data_hit_out(dhit),
        .data_cmode_out(dcm), .data_wp_fault_out(wpf), .miss_in(miss),
        .miss_addr_in(ma), .beat_ack_in(ack), .fill_req_out(freq),
        .fill_addr_out(faddr), .fill_last_out(flast), .wr_pend_in(pend),
        .wr_size_in(wsz), .wr_go_out(wgo), .xfer_size_out(xsz));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // One strobe; read data and violation stand in the next cycle only
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic v);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        q = rdat;
        v = viol;
    endtask : acc

    task automatic wrc(input logic [5:0] a, input logic [31:0] d,
                       input logic ev);
        logic [31:0] q;
        logic v;
        acc(1'b1, a, d, q, v);
        chk("wr_viol", v, ev);
    endtask : wrc

    task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                       input logic ev);
        logic [31:0] q;
        logic v;
        acc(1'b0, a, 32'h0, q, v);
        chk("rdata", q, e);
        chk("rd_viol", v, ev);
    endtask : rdc

    task automatic look(input logic [31:0] f, input logic [31:0] d,
                        input logic w);
        @(posedge clk);
        fa <= f;
        da <= d;
        dw <= w;
        tick(2);
    endtask : look

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 15; i++) begin
            wrc(i[5:0], 32'ha5000000 | i, 1'b0);
        end
        for (int i = 0; i < 15; i++) begin
            rdc(i[5:0], 32'ha5000000 | i, 1'b0);
        end
        wrc(6'h3f, 32'h12345678, 1'b0);
        rdc(6'h3f, 32'h0, 1'b0);
        rdc(IDX_STATUS, 32'h00002700, 1'b0);
        wrc(IDX_FLAGS, 32'hffffff15, 1'b0);
        rdc(IDX_STATUS, 32'h00002715, 1'b0);
    endtask : t_regs

    task automatic t_stack;
        wrc(IDX_USP, 32'h3333, 1'b0);
        wrc(IDX_ISP, 32'h1111, 1'b0);
        wrc(IDX_MSP, 32'h2222, 1'b0);
        rdc(IDX_A7, 32'h1111, 1'b0);
        wrc(IDX_STATUS, 32'h3000, 1'b0);
        rdc(IDX_A7, 32'h2222, 1'b0);
        wrc(IDX_A7, 32'h4444, 1'b0);
        rdc(IDX_MSP, 32'h4444, 1'b0);
        rdc(IDX_ISP, 32'h1111, 1'b0);
    endtask : t_stack

    task automatic t_codes;
        logic [2:0] cs [5] = '{3'b100, 3'b000, 3'b010, 3'b001, 3'b011};
        logic [2:0] ex [5] = '{FC_SPROG, FC_SDATA, 3'h3, 3'h4, 3'h3};
        wrc(IDX_SFC, 32'h3, 1'b0);
        wrc(IDX_DFC, 32'h4, 1'b0);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {ap, as, ad} <= cs[i];
            tick(2);
            chk("fc", fc, ex[i]);
        end
        @(posedge clk);
        {ap, as, ad} <= 3'b000;
        vn <= 8'h40;
        wrc(IDX_VBR, 32'h00010000, 1'b0);
        tick(2);
        chk("vector_addr", vaddr, 32'h00010100);
    endtask : t_codes

    task automatic t_blocks;
        wrc(IDX_FETCH0, 32'h40008020, 1'b0);
        wrc(IDX_FETCH1, 32'h40008060, 1'b0);
        wrc(IDX_OPND1, 32'h80018044, 1'b0);
        look(32'h40001234, 32'h0, 1'b0);
        chk("fetch_cmode_off", fcm, CM_NOCACHE);
        wrc(IDX_CACHE, 32'h1, 1'b0);
        chk("icache_en", {dc, ic}, 2'b01);
        wrc(IDX_CACHE, 32'h3, 1'b0);
        chk("dcache_en", {dc, ic}, 2'b11);
        look(32'h40001234, 32'h81000010, 1'b1);
        chk("f_hit", {fhit, fcm}, {1'b1, CM_COPYBACK});
        chk("d_hit", {dhit, dcm, wpf}, {1'b1, CM_SERIAL, 1'b1});
        look(32'h41000000, 32'h80000010, 1'b0);
        chk("fetch_miss", {fhit, fcm}, {1'b0, CM_WTHRU});
        chk("d_rd", {dhit, dcm, wpf}, {1'b1, CM_SERIAL, 1'b0});
    endtask : t_blocks

    task automatic t_fill;
        @(posedge clk);
        pend <= 1'b1;
        miss <= 1'b1;
        ma <= 32'h12345678;
        @(posedge clk);
        miss <= 1'b0;
        ack <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            #1;
            chk("fill_req", freq, 1'b1);
            chk("fill_addr", faddr, 32'h12345670 + 4 * b);
            chk("fill_last", flast, b == 3);
            chk("wr_go", {wgo, xsz}, {1'b0, SZ_LINE});
            @(posedge clk);
            miss <= (b == 0);
        end
        ack <= 1'b0;
        #1;
        chk("fill_done", freq, 1'b0);
        chk("wr_go_after", {wgo, xsz}, {1'b1, SZ_WORD});
        @(posedge clk);
        pend <= 1'b0;
    endtask : t_fill

    // Leaves the model in user mode, so it runs last
    task automatic t_user;
        wrc(IDX_STATUS, 32'h0, 1'b0);
        tick(2);
        chk("super_mode", sup, 1'b0);
        wrc(IDX_VBR, 32'h0bad0000, 1'b1);
        tick(2);
        chk("vector_kept", vaddr, 32'h00010100);
        rdc(IDX_STATUS, 32'h0, 1'b1);
        rdc(IDX_FETCH0, 32'h0, 1'b1);
        wrc(IDX_OPND0, 32'hffffffff, 1'b1);
        wrc(IDX_OPND1, 32'h0, 1'b1);
        // A leaked write to either operand control would change this mode
        look(32'h0, 32'h80000010, 1'b0);
        chk("blk_kept", dcm, CM_SERIAL);
        rdc(IDX_USP, 32'h0, 1'b1);
        rdc(IDX_A7, 32'h3333, 1'b0);
        wrc(IDX_FLAGS, 32'h5, 1'b0);
        chk("fc_udata", fc, FC_UDATA);
        @(posedge clk);
        ap <= 1'b1;
        tick(2);
        chk("fc_uprog", fc, FC_UPROG);
    endtask : t_user

    task automatic results;
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        chk("reset_state", {sup, freq, fcm, dcm}, {2'b10, CM_NOCACHE,
            CM_NOCACHE});
        t_regs();
        t_stack();
        t_codes();
        t_blocks();
        t_fill();
        t_user();
        results();
    end
endmodule : priv_reg_model_bench
`default_nettype wire
